// ==== rtl/fbc_pkg.sv ====
// fbc_pkg: constants and carrier types for the flash bus controller
// assumes a 125 MHz system clock; times are converted to cycle counts here
package fbc_pkg;

  localparam int CLK_PERIOD_PS = 8000;

  // pin and data widths
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;

  // reset and wake-up times as documented, in their own units
  localparam int RESET_PULSE_WIDTH_NS    = 100;
  localparam int ABORT_ERASE_US          = 22;
  localparam int ABORT_PROGRAM_US        = 12;
  localparam int READ_WAKEUP_TIME_NS     = 150;
  localparam int WRITE_WAKEUP_TIME_WE_NS = 150;

  // bus cycle timing in ns
  localparam int READ_ACCESS_NS  = 70;
  localparam int WRITE_PULSE_NS  = 45;
  localparam int WRITE_SETUP_NS  = 10;

  function automatic int ns_up(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // least times round up to whole cycles
  localparam int RESET_PULSE_CYC = ns_up(RESET_PULSE_WIDTH_NS);
  localparam int ABORT_CYC       = ns_up(ABORT_ERASE_US * 1000);
  localparam int READ_WAKE_CYC   = ns_up(READ_WAKEUP_TIME_NS);
  localparam int WRITE_WAKE_CYC  = ns_up(WRITE_WAKEUP_TIME_WE_NS);
  localparam int READ_ACC_CYC    = ns_up(READ_ACCESS_NS) + 2;
  localparam int WRITE_PULSE_CYC = ns_up(WRITE_PULSE_NS);
  localparam int WRITE_SETUP_CYC = ns_up(WRITE_SETUP_NS);

  localparam int CNT_W = 16;

  // commands written to the command interface
  localparam logic [DATA_W-1:0] CMD_READ_ARRAY = 16'h00FF;
  localparam logic [DATA_W-1:0] CMD_READ_STAT  = 16'h0070;
  localparam logic [7:0]        STATUS_READY   = 8'h80;

  // user-side request and pin bundle
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fbc_req_type;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_powerdown_n;
  } fbc_ctl_type;

endpackage

// ==== rtl/fbc_timer.sv ====
// fbc_timer: loadable down-counter giving a done pulse
// assumes the load value is at least one
`timescale 1ns/1ps
`default_nettype none
module fbc_timer #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              busy,
  output logic              done
);

  logic [W-1:0] cnt_reg;

  // count down to zero after a load
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= value;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  assign busy = (cnt_reg != '0);
  assign done = (cnt_reg == W'(1)) && !load;

endmodule
`default_nettype wire

// ==== rtl/fbc_ctrl.sv ====
// fbc_ctrl: host-side controller driving the flash pins
// assumes flash pins are sampled asynchronously and the bus pad resolves dq from dq_oe
//
// Overview of operation
// - read needs ce, oe low, we, reset high
// - write needs ce, we low, oe high
// - wait wake-up times before reads, writes
// - after abort, wake-up counts from shutdown end
// - drive reset from processor reset
// - hold reset low minimum pulse width
// - issue read array after program/erase (fbc_ctrl issues no commands itself; the user must write CMD_READ_ARRAY)
`timescale 1ns/1ps
`default_nettype none
module fbc_ctrl
  import fbc_pkg::*;
#(
  parameter int ABORT_CYCLES = fbc_pkg::ABORT_CYC
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // user request side
  input  wire logic                         req_valid,
  input  wire fbc_pkg::fbc_req_type         req,
  output logic                              req_ready,
  input  wire logic                         flash_reset_req,
  input  wire logic                         op_running,
  output logic                              rsp_valid,
  output logic [fbc_pkg::DATA_W-1:0]        rsp_data,
  // flash pins
  output fbc_pkg::fbc_ctl_type              ctl,
  output logic [fbc_pkg::ADDR_W-1:0]        addr,
  output logic [fbc_pkg::DATA_W-1:0]        dq_out,
  output logic                              dq_oe,
  input  wire logic [fbc_pkg::DATA_W-1:0]   dq_in
);

  import fbc_pkg::*;

  typedef enum {ST_RESET, ST_SHUTDOWN, ST_WAKE, ST_IDLE, ST_RD, ST_WR_SETUP, ST_WR_PULSE,
                ST_WR_HOLD} fbc_state_type;

  fbc_state_type       state_reg;
  fbc_state_type       state_next;
  logic [DATA_W-1:0]   dq_s1_reg;
  logic [DATA_W-1:0]   dq_s2_reg;
  logic                timer_load;
  logic [CNT_W-1:0]    timer_value;
  logic                timer_busy;
  logic                boot_reg;
  logic                aborting;

  ////////////////////////////////////////////////////////////////
  // shared timer for pulse widths, wake-up and shutdown
  fbc_timer #(.W(CNT_W)) u_timer (
    .clk   (clk),
    .rst   (rst),
    .load  (timer_load),
    .value (timer_value),
    .busy  (timer_busy),
    .done  ()
  );

  // two-flop synchroniser for returning data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dq_s1_reg <= '0;
      dq_s2_reg <= '0;
    end else begin
      dq_s1_reg <= dq_in;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  assign aborting = op_running;

  ////////////////////////////////////////////////////////////////
  // next-state and timer loads
  always_comb begin
    state_next  = state_reg;
    timer_load  = 1'b0;
    timer_value = '0;
    case (state_reg)
      ST_RESET: begin
        // hold reset at least the pulse width; abort takes the shutdown time
        if (boot_reg) begin
          // pin was low only while rst stood: stretch it to the least width
          timer_load  = 1'b1;
          timer_value = CNT_W'(RESET_PULSE_CYC);
        end else if (!flash_reset_req && !timer_busy) begin
          state_next  = ST_WAKE;
          timer_load  = 1'b1;
          timer_value = CNT_W'(WRITE_WAKE_CYC);
        end
      end
      ST_SHUTDOWN: begin
        // wait out the abort shutdown before counting wake-up
        if (!timer_busy) begin
          state_next = ST_RESET;
        end
      end
      ST_WAKE: begin
        if (flash_reset_req) begin
          state_next  = ST_RESET;
          timer_load  = 1'b1;
          timer_value = CNT_W'(RESET_PULSE_CYC);
        end else if (!timer_busy) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (flash_reset_req) begin
          // processor reset drives flash reset
          state_next  = aborting ? ST_SHUTDOWN : ST_RESET;
          timer_load  = 1'b1;
          timer_value = aborting ? CNT_W'(ABORT_CYCLES) : CNT_W'(RESET_PULSE_CYC);
        end else if (req_valid && req.write) begin
          state_next  = ST_WR_SETUP;
          timer_load  = 1'b1;
          timer_value = CNT_W'(WRITE_SETUP_CYC);
        end else if (req_valid) begin
          state_next  = ST_RD;
          timer_load  = 1'b1;
          timer_value = CNT_W'(READ_ACC_CYC);
        end
      end
      ST_RD: begin
        if (!timer_busy) begin
          state_next = ST_IDLE;
        end
      end
      ST_WR_SETUP: begin
        if (!timer_busy) begin
          state_next  = ST_WR_PULSE;
          timer_load  = 1'b1;
          timer_value = CNT_W'(WRITE_PULSE_CYC);
        end
      end
      ST_WR_PULSE: begin
        if (!timer_busy) begin
          state_next  = ST_WR_HOLD;
          timer_load  = 1'b1;
          timer_value = CNT_W'(WRITE_SETUP_CYC);
        end
      end
      ST_WR_HOLD: begin
        if (!timer_busy) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_RESET;
      end
    endcase
  end

  // state register; start in reset so the flash is held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // marks the first cycle out of rst, so the reset pin is held for its least width
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin drive: control strobes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_powerdown_n: 1'b0};
    end else begin
      ctl.reset_powerdown_n <= !(state_next inside {ST_RESET, ST_SHUTDOWN});
      ctl.ce_n <= !(state_next inside {ST_RD, ST_WR_SETUP, ST_WR_PULSE});
      ctl.oe_n <= !(state_next == ST_RD);
      ctl.we_n <= !(state_next == ST_WR_PULSE);
    end
  end

  // address and write data stay stable across the strobe and its release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr   <= '0;
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end else begin
      if (state_reg == ST_IDLE && state_next != ST_IDLE && !flash_reset_req) begin
        addr   <= req.addr;
        dq_out <= req.data;
      end
      dq_oe <= state_next inside {ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD};
    end
  end

  // read data capture at the end of the access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end else begin
      rsp_valid <= (state_reg == ST_RD) && !timer_busy;
      if ((state_reg == ST_RD) && !timer_busy) begin
        rsp_data <= dq_s2_reg;
      end
    end
  end

  assign req_ready = (state_reg == ST_IDLE) && !flash_reset_req;

endmodule
`default_nettype wire

// ==== sim/fbc_props.sv ====
// fbc_props: pin timing checks for the flash bus controller
// assumes it is bound onto fbc_ctrl and shares its abort length
`timescale 1ns/1ps
`default_nettype none
module fbc_props
  import fbc_pkg::*;
#(
  parameter int ABORT_CYCLES = fbc_pkg::ABORT_CYC
) (
  // clock, reset and user side
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 req_valid,
  input wire fbc_pkg::fbc_req_type req,
  input wire logic                 req_ready,
  input wire logic                 flash_reset_req,
  input wire logic                 op_running,
  input wire logic                 rsp_valid,
  // flash pins
  input wire fbc_pkg::fbc_ctl_type ctl,
  input wire logic [ADDR_W-1:0]    addr,
  input wire logic [DATA_W-1:0]    dq_out,
  input wire logic                 dq_oe
);
  logic [15:0] low_reg;
  logic [15:0] high_reg;
  logic        abort_reg;
  ////////////////////////////////////////////////////////////////
  // cycles spent with the reset pin low and high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_reg  <= 16'h0000;
      high_reg <= 16'h0000;
    end else begin
      low_reg  <= ctl.reset_powerdown_n ? 16'h0000 : low_reg + 16'h0001;
      high_reg <= ctl.reset_powerdown_n ? high_reg + 16'h0001 : 16'h0000;
    end
  end
  // whether an operation was running when the pin fell
  always_ff @(posedge clk or posedge rst) begin
    if (rst) abort_reg <= 1'b0;
    else if (ctl.reset_powerdown_n) abort_reg <= op_running;
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd_take; req_valid && req_ready && !req.write; endsequence
  sequence s_wr_take; req_valid && req_ready && req.write; endsequence
  property p_read_pins; !ctl.oe_n |-> !ctl.ce_n && ctl.we_n && ctl.reset_powerdown_n && !dq_oe; endproperty
  property p_read_done; s_rd_take |-> ##[2:30] rsp_valid; endproperty
  property p_write_pins; !ctl.we_n |-> !ctl.ce_n && ctl.oe_n && ctl.reset_powerdown_n && dq_oe; endproperty
  property p_write_data; s_wr_take |-> ##2 dq_oe && dq_out == $past(req.data, 2) && addr == $past(req.addr, 2); endproperty
  property p_pulse; $rose(ctl.reset_powerdown_n) |-> low_reg >= RESET_PULSE_CYC; endproperty
  property p_abort; $rose(ctl.reset_powerdown_n) && abort_reg |-> low_reg >= ABORT_CYCLES; endproperty
  property p_wake; $fell(ctl.ce_n) |-> high_reg >= WRITE_WAKE_CYC; endproperty
  property p_reset_go; $rose(flash_reset_req) |-> ##[1:60] !ctl.reset_powerdown_n; endproperty
  a_read_pins: assert property (p_read_pins) else $error("read pins wrong");
  a_read_done: assert property (p_read_done) else $error("read not answered");
  a_write_pins: assert property (p_write_pins) else $error("write pins wrong");
  a_write_data: assert property (p_write_data) else $error("write data wrong");
  a_pulse: assert property (p_pulse) else $error("reset pulse short");
  a_abort: assert property (p_abort) else $error("abort shutdown short");
  a_wake: assert property (p_wake) else $error("access before wake");
  a_reset_go: assert property (p_reset_go) else $error("reset not passed on");
endmodule
bind fbc_ctrl fbc_props #(.ABORT_CYCLES(ABORT_CYCLES)) fbc_props_i (.clk(clk), .rst(rst), .req_valid(req_valid),
  .req(req), .req_ready(req_ready), .flash_reset_req(flash_reset_req), .op_running(op_running),
  .rsp_valid(rsp_valid), .ctl(ctl), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe));
`default_nettype wire

// ==== sim/fbc_flash_model.sv ====
// fbc_flash_model: behavioural flash device behind the controller pins
// assumes the controller resolves nothing; dq is the wire level
`timescale 1ns/1ps
`default_nettype none
module fbc_flash_model
  import fbc_pkg::*;
(
  // control pins
  input  wire fbc_pkg::fbc_ctl_type ctl,
  input  wire logic [ADDR_W-1:0]    addr,
  input  wire logic                 op_running,
  // data bus pieces
  input  wire logic [DATA_W-1:0]    dq_out,
  input  wire logic                 dq_oe,
  output logic [DATA_W-1:0]         dq
);
  logic        stat_mode = 1'b0;
  logic [7:0]  status = STATUS_READY;
  logic        armed = 1'b0;
  logic [15:0] last = 16'h0000;
  logic        drive;
  logic [15:0] rdata;
  logic [7:0]  stat_now;
  // one process owns the command state: reset, write open, write close
  always @(ctl) begin
    if (!ctl.reset_powerdown_n) begin
      // reset low: read-array mode, ready status, open write dropped
      // an operation in flight is cut here and its data lost
      stat_mode = 1'b0;
      status    = STATUS_READY;
      armed     = 1'b0;
    end else if (!ctl.we_n && !ctl.ce_n) begin
      // a write cycle opens with both strobes low
      armed = 1'b1;
    end else if (armed) begin
      // command taken on the first rising strobe, at any address
      armed = 1'b0;
      if (dq === CMD_READ_STAT) stat_mode = 1'b1;
      if (dq === CMD_READ_ARRAY) stat_mode = 1'b0;
    end
  end
  // a running operation shows busy in bit 7 and goes on when deselected
  assign stat_now = op_running ? {1'b0, status[6:0]} : status;
  // outputs only when selected, enabled, not writing and out of reset
  assign drive = ctl.reset_powerdown_n && !ctl.ce_n && !ctl.oe_n && ctl.we_n;
  assign rdata = stat_mode ? {8'h00, stat_now} : addr[15:0] ^ 16'ha5c3;
  always @* if (drive) last = rdata;
  // released bus shows the inverse of the last word
  assign dq = dq_oe ? dq_out : (drive ? rdata : ~last);
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// testbench: fbc_ctrl against the flash model, reads checked by a bench model
// assumes package, controller, model and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_total++; $display("ERROR %s exp %h got %h", n, e, s); end end
module testbench;
  import fbc_pkg::*;
  logic                 clk;
  logic                 rst = 1'b1;
  logic                 req_valid = 1'b0;
  fbc_req_type          req = '0;
  logic                 flash_reset_req = 1'b0;
  logic                 op_running = 1'b0;
  logic                 req_ready, rsp_valid, dq_oe;
  logic [DATA_W-1:0]    rsp_data, dq_out, dq_in, exp_w;
  logic [ADDR_W-1:0]    addr;
  fbc_ctl_type          ctl;
  logic [15:0]          exp_q[$];
  logic                 stat_m = 1'b0;
  int                   err_total = 0;
  int                   checks_done = 0;
  fbc_ctrl #(.ABORT_CYCLES(20)) fbc_ctrl_i (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .flash_reset_req(flash_reset_req), .op_running(op_running), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .ctl(ctl), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  fbc_flash_model fbc_flash_model_i (.ctl(ctl), .addr(addr), .op_running(op_running), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq(dq_in));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // one request, held until taken; bench model updated alongside
  task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{w, a, d};
    for (n = 0; n < 3000 && req_ready !== 1'b1; n++) @(negedge clk);
    if (n >= 3000) err_total++;
    if (!w) exp_q.push_back(stat_m ? {8'h00, STATUS_READY} : a[15:0] ^ 16'ha5c3);
    if (w && d === CMD_READ_STAT) stat_m = 1'b1;
    if (w && d === CMD_READ_ARRAY) stat_m = 1'b0;
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // each read answer against the oldest expected word
  always @(negedge clk) if (rsp_valid === 1'b1) begin
    exp_w = exp_q.pop_front();
    `CHK("read data", exp_w, rsp_data)
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hdbb75f99));
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      case (i % 8)
        1: op(1'b1, ADDR_W'($urandom), CMD_READ_STAT);
        6: op(1'b1, ADDR_W'($urandom), CMD_READ_ARRAY);
        4: begin
          while (req_ready !== 1'b1) @(negedge clk);
          op_running = i[3];
          flash_reset_req = 1'b1;
          // request shorter than the least width and the shutdown: the controller stretches it
          repeat (2 + $urandom % 8) @(negedge clk);
          flash_reset_req = 1'b0;
          op_running = 1'b0;
          stat_m = 1'b0;
        end
        default: op(1'b0, ADDR_W'($urandom), DATA_W'($urandom));
      endcase
    end
    repeat (40) @(negedge clk);
    `CHK("pending reads", 0, exp_q.size())
    complete_run;
  end
  // hang guard
  initial begin
    #200000;
    err_total++;
    complete_run;
  end
endmodule
`default_nettype wire
